// ==== rtl/eepfe_top.sv ====
/*
 * slave front end: start/stop detection, bit capture, select decode, ack drive.
 * assumes an open-drain bus outside resolving sda from sda_oe; write cycle timing
 * and memory access live elsewhere and report through write_busy.
 */
`timescale 1ns/10ps
module eepfe_top
    import eepfe_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       ce,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    output logic                            scl_out,
    output logic                            scl_oe,
    input  wire logic                       chip_enable_address_pin,
    input  wire logic                       write_protect_input,
    input  wire logic                       write_busy,
    input  wire logic                       tx_bit,
    output logic                            selected,
    output logic                            id_page_sel,
    output logic                            read_req,
    output logic [1:0]                      upper_addr,
    output logic [7:0]                      addr_byte,
    output logic                            addr_valid,
    output logic [7:0]                      data_byte,
    output logic                            data_valid,
    output logic                            write_start,
    output logic                            busy_ignored
);
    logic            rst_meta;
    logic            rst_n;
    logic            scl;
    logic            sda;
    logic            scl_d;
    logic            sda_d;
    logic            ce_sync_a;
    logic            ce_sync_b;
    logic            wp_sync_a;
    logic            wp_sync_b;
    logic            busy_sync_a;
    logic            busy_sync_b;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_seen;
    logic            stop_seen;
    eepfe_state_type state;
    logic [3:0]      bit_count;
    logic [7:0]      shift;
    logic            write_pending;
    logic            pull_low;
    logic            ack_ok;
    logic [7:0]      next_shift;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ---------------------------------------------------------------
    // line conditioning
    // ---------------------------------------------------------------
    eepfe_filter u_scl (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (scl_in),
        .level (scl)
    );

    eepfe_filter u_sda (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (sda_in),
        .level (sda)
    );

    // a floating pin is resolved to 0 by the pad's pull-down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ce_sync_a   <= 1'b0;
            ce_sync_b   <= 1'b0;
            wp_sync_a   <= 1'b0;
            wp_sync_b   <= 1'b0;
            busy_sync_a <= 1'b0;
            busy_sync_b <= 1'b0;
        end else if (ce) begin
            ce_sync_a   <= chip_enable_address_pin;
            ce_sync_b   <= ce_sync_a;
            wp_sync_a   <= write_protect_input;
            wp_sync_b   <= wp_sync_a;
            busy_sync_a <= write_busy;
            busy_sync_b <= busy_sync_a;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce) begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    assign scl_rise   = scl & ~scl_d;
    assign scl_fall   = ~scl & scl_d;
    assign start_seen = scl & scl_d & sda_d & ~sda & ~busy_sync_b;
    assign stop_seen  = scl & scl_d & ~sda_d & sda;
    assign next_shift = {shift[6:0], sda};

    // ---------------------------------------------------------------
    // byte sequencing
    // ---------------------------------------------------------------
    // select decode: type, chip enable bit; read by ack logic in the ninth period
    always_comb begin
        ack_ok = 1'b0;
        unique case (state)
            EEPFE_SEL_ACK: begin
                ack_ok = ((shift[7:SEL_TYPE_LSB] == TYPE_ARRAY) ||
                          (shift[7:SEL_TYPE_LSB] == TYPE_ID_PAGE)) &&
                         (shift[SEL_CE_BIT] == ce_sync_b);
            end
            EEPFE_ADDR_ACK: ack_ok = 1'b1;
            EEPFE_DATA_ACK: ack_ok = ~read_req & ~wp_sync_b;
            EEPFE_IDLE, EEPFE_SELECT, EEPFE_ADDR, EEPFE_DATA: ack_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= EEPFE_IDLE;
            bit_count <= 4'h0;
            shift     <= 8'h00;
        end else if (ce) begin
            if (busy_sync_b) begin
                state     <= EEPFE_IDLE;
                bit_count <= 4'h0;
            end else if (start_seen) begin
                state     <= EEPFE_SELECT;
                bit_count <= 4'h0;
            end else if (stop_seen) begin
                state <= EEPFE_IDLE;
            end else begin
                unique case (state)
                    EEPFE_IDLE: state <= EEPFE_IDLE;
                    EEPFE_SELECT, EEPFE_ADDR, EEPFE_DATA: begin
                        if (scl_rise) begin
                            shift     <= next_shift;
                            bit_count <= bit_count + 4'h1;
                        end
                        if (scl_fall && bit_count == BITS_PER_BYTE) begin
                            bit_count <= 4'h0;
                            unique case (state)
                                EEPFE_SELECT: state <= EEPFE_SEL_ACK;
                                EEPFE_ADDR:   state <= EEPFE_ADDR_ACK;
                                default:      state <= EEPFE_DATA_ACK;
                            endcase
                        end
                    end
                    EEPFE_SEL_ACK, EEPFE_ADDR_ACK, EEPFE_DATA_ACK: begin
                        if (scl_fall) begin
                            if (state == EEPFE_SEL_ACK && !ack_ok) begin
                                state <= EEPFE_IDLE;
                            // read_req is only latched on this same edge, so use the byte
                            end else if (state == EEPFE_SEL_ACK && shift[SEL_RW_BIT]) begin
                                state <= EEPFE_DATA;
                            end else if (state == EEPFE_SEL_ACK) begin
                                state <= EEPFE_ADDR;
                            end else begin
                                state <= EEPFE_DATA;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // select fields are latched as the ninth period ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            selected    <= 1'b0;
            id_page_sel <= 1'b0;
            read_req    <= 1'b0;
            upper_addr  <= 2'h0;
        end else if (ce) begin
            if (start_seen || stop_seen || busy_sync_b) begin
                selected <= 1'b0;
            end else if (state == EEPFE_SEL_ACK && scl_fall) begin
                selected    <= ack_ok;
                id_page_sel <= shift[SEL_TYPE_LSB];
                read_req    <= shift[SEL_RW_BIT];
                upper_addr  <= shift[SEL_TYPE_LSB] ? 2'h0 :
                               {shift[SEL_A9_BIT], shift[SEL_A8_BIT]};
            end
        end
    end

    // ---------------------------------------------------------------
    // received bytes and write trigger
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_byte     <= 8'h00;
            addr_valid    <= 1'b0;
            data_byte     <= 8'h00;
            data_valid    <= 1'b0;
            write_pending <= 1'b0;
            write_start   <= 1'b0;
        end else if (ce) begin
            addr_valid  <= 1'b0;
            data_valid  <= 1'b0;
            write_start <= 1'b0;
            if (scl_fall && state == EEPFE_ADDR && bit_count == BITS_PER_BYTE) begin
                addr_byte  <= shift;
                addr_valid <= 1'b1;
            end
            if (scl_fall && state == EEPFE_DATA && bit_count == BITS_PER_BYTE &&
                !read_req) begin
                data_byte  <= shift;
                data_valid <= ~wp_sync_b;
            end
            if (start_seen || busy_sync_b) begin
                write_pending <= 1'b0;
            end else if (stop_seen) begin
                write_start   <= write_pending;
                write_pending <= 1'b0;
            end else if (state == EEPFE_DATA_ACK && scl_fall && ack_ok) begin
                write_pending <= 1'b1;
            end else if (scl_fall && state == EEPFE_DATA) begin
                // stop rides on the tenth clock high; a later fall means more data
                write_pending <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // data pin drive
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_low <= 1'b0;
        end else if (ce) begin
            if (start_seen || stop_seen || busy_sync_b) begin
                pull_low <= 1'b0;
            end else if (scl_fall) begin
                unique case (state)
                    EEPFE_SELECT, EEPFE_ADDR:
                        pull_low <= (bit_count == BITS_PER_BYTE);
                    EEPFE_DATA:
                        pull_low <= read_req ? ~tx_bit && bit_count != BITS_PER_BYTE :
                                    bit_count == BITS_PER_BYTE && ~wp_sync_b;
                    EEPFE_SEL_ACK:
                        pull_low <= ack_ok && shift[SEL_RW_BIT] && ~tx_bit;
                    EEPFE_ADDR_ACK, EEPFE_DATA_ACK, EEPFE_IDLE:
                        pull_low <= 1'b0;
                endcase
            end
        end
    end

    // select ack is withheld on mismatch by gating with ack_ok in the ninth period
    assign sda_out      = 1'b0;
    assign sda_oe       = pull_low & ((state != EEPFE_SEL_ACK) | ack_ok);
    assign scl_out      = 1'b0;
    assign scl_oe       = 1'b0;
    assign busy_ignored = busy_sync_b;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_sda_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
        sda_out == 1'b0) else $error("data pin driven high");
    a_scl_never_driven: assert property (@(posedge clk) disable iff (!rst_n)
        !scl_oe) else $error("clock pin driven");
    a_start_enters_sel: assert property (@(posedge clk) disable iff (!rst_n)
        ce && start_seen |=> state == EEPFE_SELECT) else $error("start missed");
    a_stop_goes_idle: assert property (@(posedge clk) disable iff (!rst_n)
        ce && stop_seen && !start_seen && !busy_sync_b |=> state == EEPFE_IDLE)
        else $error("stop ignored");
    a_busy_ignores_bus: assert property (@(posedge clk) disable iff (!rst_n)
        ce && busy_sync_b |=> state == EEPFE_IDLE && !sda_oe)
        else $error("bus served during write cycle");

    // select byte complete on the eighth fall, then the ack slot with the pull armed
    sequence s_sel_byte_end;
        ce && !start_seen && !stop_seen && !busy_sync_b && scl_fall &&
        state == EEPFE_SELECT && bit_count == BITS_PER_BYTE;
    endsequence

    sequence s_sel_ack_armed;
        state == EEPFE_SEL_ACK && pull_low;
    endsequence

    a_sel_ack_drive: assert property (@(posedge clk) disable iff (!rst_n)
        s_sel_byte_end |=> s_sel_ack_armed)
        else $error("select ack slot not armed");
    a_wp_no_data_ack: assert property (@(posedge clk) disable iff (!rst_n)
        state == EEPFE_DATA_ACK && wp_sync_b && $stable(wp_sync_b) |-> !ack_ok)
        else $error("data acked under protect");
    a_wp_no_write: assert property (@(posedge clk) disable iff (!rst_n)
        data_valid |-> !$past(wp_sync_b)) else $error("write under protect");
    a_bad_type_nak: assert property (@(posedge clk) disable iff (!rst_n)
        state == EEPFE_SEL_ACK && shift[7:5] != 3'h5 |-> !ack_ok)
        else $error("bad type acked");
    a_ce_mismatch_nak: assert property (@(posedge clk) disable iff (!rst_n)
        state == EEPFE_SEL_ACK && shift[SEL_CE_BIT] != ce_sync_b |-> !sda_oe)
        else $error("wrong chip acked");
    a_write_needs_stop: assert property (@(posedge clk) disable iff (!rst_n)
        write_start |-> $past(stop_seen)) else $error("write without stop");
endmodule

// ==== inc/eepfe_pkg.sv ====
/*
 * constants, types and the mode list of the serial memory slave front end.
 * assumes a 100 MHz system clock that oversamples the serial clock and data pins.
 */
package eepfe_pkg;

    // ---------------------------------------------------------------
    // memory geometry
    // ---------------------------------------------------------------
    localparam int PAGE_COUNT      = 64;
    localparam int PAGE_BYTES      = 16;
    localparam int ID_PAGE_BYTES   = 16;
    localparam int ARRAY_ADDR_BITS = 10;

    // ---------------------------------------------------------------
    // select byte layout
    // ---------------------------------------------------------------
    localparam logic [3:0] TYPE_ARRAY   = 4'ha;
    localparam logic [3:0] TYPE_ID_PAGE = 4'hb;
    localparam int SEL_TYPE_LSB = 4;
    localparam int SEL_CE_BIT   = 3;
    localparam int SEL_A9_BIT   = 2;
    localparam int SEL_A8_BIT   = 1;
    localparam int SEL_RW_BIT   = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ---------------------------------------------------------------
    // filtering and timing
    // ---------------------------------------------------------------
    localparam int FILTER_NS     = 50;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        EEPFE_IDLE,
        EEPFE_SELECT,
        EEPFE_SEL_ACK,
        EEPFE_ADDR,
        EEPFE_ADDR_ACK,
        EEPFE_DATA,
        EEPFE_DATA_ACK
    } eepfe_state_type;

endpackage

// ==== rtl/eepfe_filter.sv ====
/*
 * two-flop synchroniser plus glitch filter for one bus line.
 * assumes the input is asynchronous to clk; output changes only after a stable run.
 */
`timescale 1ns/10ps
module eepfe_filter
    import eepfe_pkg::*;
#(
    parameter int STABLE = FILTER_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin,
    output logic      level
);
    logic       sync_a;
    logic       sync_b;
    logic [3:0] run;

    // ---------------------------------------------------------------
    // synchroniser; lines idle high under pull-up
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else if (ce) begin
            sync_a <= pin;
            sync_b <= sync_a;
        end
    end

    // ---------------------------------------------------------------
    // filter: short spikes never reach the edge detectors
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run   <= 4'h0;
            level <= 1'b1;
        end else if (ce) begin
            if (sync_b == level) begin
                run <= 4'h0;
            end else if (run == 4'(STABLE - 1)) begin
                run   <= 4'h0;
                level <= sync_b;
            end else begin
                run <= run + 4'h1;
            end
        end
    end
endmodule

// ==== bench/eepfe_bus_master.sv ====
/*
 * behavioural serial bus master that drives the slave front end.
 * assumes pull-ups outside resolve both lines from the pull outputs.
 */
`timescale 1ns/10ps
module eepfe_bus_master #(
    parameter int QUARTER_NS = 80
) (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_pull,
    output logic      sda_pull
);
    // ---------------------------------------------------------------
    // line control
    // ---------------------------------------------------------------
    // phases are one fifth of a bit period (QUARTER_NS) or more so the slave filter passes them
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    task automatic bus_start;
        sda_pull = 1'b1;
        #(2 * QUARTER_NS);
        scl_pull = 1'b1;
    endtask

    task automatic bus_stop;
        #(2 * QUARTER_NS);
        sda_pull = 1'b1;
        #(QUARTER_NS);
        scl_pull = 1'b0;
        #(2 * QUARTER_NS);
        sda_pull = 1'b0;
        #(2 * QUARTER_NS);
    endtask

    // data changes deep inside the low phase, never near an edge
    task automatic clock_bit(input logic v, output logic seen);
        #(2 * QUARTER_NS);
        sda_pull = ~v;
        #(QUARTER_NS);
        scl_pull = 1'b0;
        #(QUARTER_NS);
        seen = sda_line;
        #(QUARTER_NS);
        scl_pull = 1'b1;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, ack);
    endtask
endmodule

// ==== bench/test_eeprom_i2c_slave_front_end.sv ====
/*
 * self-checking bench of the slave front end with a bus master model.
 * assumes the open-drain lines are resolved here with pull-ups.
 */
`timescale 1ns/10ps
module test_eeprom_i2c_slave_front_end import eepfe_pkg::*;;
    logic       clk, arst_n, ce, chip_pin, wp, wbusy, tx_bit;
    logic       scl_pull, sda_pull, sda_out, sda_oe, scl_out, scl_oe;
    logic       selected, id_page_sel, read_req, addr_valid, data_valid;
    logic       write_start, busy_ignored;
    logic [1:0] upper_addr;
    logic [7:0] addr_byte, data_byte, last_addr, last_data, dv_cnt, ws_cnt;
    wire logic  scl_line, sda_line;
    int         miscompares, cmp_count, cycles;

    assign sda_line = !(sda_pull || sda_oe);
    assign scl_line = !(scl_pull || scl_oe);

    eepfe_top uut (.clk(clk), .arst_n(arst_n), .ce(ce), .scl_in(scl_line),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
        .scl_oe(scl_oe), .chip_enable_address_pin(chip_pin),
        .write_protect_input(wp), .write_busy(wbusy), .tx_bit(tx_bit),
        .selected(selected), .id_page_sel(id_page_sel), .read_req(read_req),
        .upper_addr(upper_addr), .addr_byte(addr_byte), .addr_valid(addr_valid),
        .data_byte(data_byte), .data_valid(data_valid), .write_start(write_start),
        .busy_ignored(busy_ignored));

    eepfe_bus_master bm (.scl_line(scl_line), .sda_line(sda_line),
        .scl_pull(scl_pull), .sda_pull(sda_pull));

    // ---------------------------------------------------------------
    // clock, pulse capture and hang guard
    // ---------------------------------------------------------------
    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (addr_valid === 1'b1) last_addr = addr_byte;
        if (data_valid === 1'b1) begin
            dv_cnt = dv_cnt + 8'h01;
            last_data = data_byte;
        end
        if (write_start === 1'b1) ws_cnt = ws_cnt + 8'h01;
        if (cycles == 40000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic drive(input logic p, input logic w, input logic b);
        @(posedge clk);
        #1;
        chip_pin = p;
        wp = w;
        wbusy = b;
        dv_cnt = 8'h00;
        ws_cnt = 8'h00;
    endtask

    task automatic select(input logic [7:0] sel, output logic ack);
        bm.bus_start();
        bm.send_byte(sel, ack);
        #200;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_write;
        logic a;
        drive(1'b0, 1'b0, 1'b0);
        select({TYPE_ARRAY, 1'b0, 2'b11, 1'b0}, a);
        check(a, 8'h00);
        check(upper_addr, 8'h03);
        check(read_req, 8'h00);
        check(id_page_sel, 8'h00);
        check({5'h00, scl_oe, scl_out, sda_out}, 8'h00);
        bm.send_byte(8'h5a, a);
        check(a, 8'h00);
        check(selected, 8'h01);
        bm.send_byte(8'h3c, a);
        check(a, 8'h00);
        check(last_addr, 8'h5a);
        bm.bus_stop();
        check(last_data, 8'h3c);
        check(ws_cnt, 8'h01);
        check(selected, 8'h00);
        $display("write test done");
    endtask

    task automatic t_types;
        logic a;
        for (int t = 0; t < 16; t++) begin
            select({t[3:0], 4'h0}, a);
            check(a, {7'h00, !(t[3:0] == TYPE_ARRAY || t[3:0] == TYPE_ID_PAGE)});
            bm.bus_stop();
        end
        $display("type test done");
    endtask

    task automatic t_chip;
        logic a;
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 2; b++) begin
                drive(p[0], 1'b0, 1'b0);
                select({TYPE_ARRAY, b[0], 3'h0}, a);
                check(a, {7'h00, p[0] != b[0]});
                bm.bus_stop();
            end
        end
        check(ws_cnt, 8'h00);
        $display("chip enable test done");
    endtask

    task automatic t_protect;
        logic a;
        drive(1'b0, 1'b1, 1'b0);
        select({TYPE_ARRAY, 4'h0}, a);
        check(a, 8'h00);
        bm.send_byte(8'h12, a);
        check(a, 8'h00);
        bm.send_byte(8'h34, a);
        check(a, 8'h01);
        bm.bus_stop();
        check(dv_cnt, 8'h00);
        check(ws_cnt, 8'h00);
        $display("protect test done");
    endtask

    task automatic t_idread;
        logic a;
        logic s;
        drive(1'b0, 1'b0, 1'b0);
        tx_bit = 1'b0;
        select({TYPE_ID_PAGE, 1'b0, 2'b11, 1'b1}, a);
        check(a, 8'h00);
        check(id_page_sel, 8'h01);
        check(read_req, 8'h01);
        check(upper_addr, 8'h00);
        // device sends a byte of zeros, then must let go for the master's ack slot
        for (int i = 0; i < 8; i++) begin
            bm.clock_bit(1'b1, s);
            check(s, 8'h00);
        end
        @(posedge clk);
        #1;
        tx_bit = 1'b1;
        bm.clock_bit(1'b1, s);
        check(s, 8'h01);
        bm.bus_stop();
        $display("identification read test done");
    endtask

    task automatic t_busy;
        logic a;
        drive(1'b0, 1'b0, 1'b1);
        select({TYPE_ARRAY, 4'h0}, a);
        check(a, 8'h01);
        check(busy_ignored, 8'h01);
        bm.bus_stop();
        drive(1'b0, 1'b0, 1'b0);
        select({TYPE_ARRAY, 4'h0}, a);
        check(a, 8'h00);
        bm.bus_stop();
        $display("busy test done");
    endtask

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        ce = 1'b1;
        chip_pin = 1'b0;
        wp = 1'b0;
        wbusy = 1'b0;
        tx_bit = 1'b1;
        miscompares = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (10) @(posedge clk);
        t_write();
        t_types();
        t_chip();
        t_protect();
        t_idread();
        t_busy();
        wrap_up();
    end
endmodule
